/* File: rtl/asp_pkg.sv */
package asp_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] ASP_OFF_PINSEL  = 8'h00;  // pin_function_select_reg
    localparam logic [7:0] ASP_OFF_ENABLE  = 8'h04;  // port enable
    localparam logic [7:0] ASP_OFF_DIVISOR = 8'h08;  // bit-rate divisor
    localparam logic [7:0] ASP_OFF_CFG     = 8'h0c;  // parity and stop config
    localparam logic [7:0] ASP_OFF_IRQ_EN  = 8'h10;  // interrupt enables (mask)
    localparam logic [7:0] ASP_OFF_IRQ_ST  = 8'h14;  // interrupt status, w1c
    localparam logic [7:0] ASP_OFF_TXBUF   = 8'h18;  // transmit buffer
    localparam logic [7:0] ASP_OFF_RXBUF   = 8'h1c;  // receive buffer
    localparam logic [7:0] ASP_OFF_LINE_ST = 8'h20;  // line status
    // field positions
    localparam int ASP_BIT_SEL       = 0;  // pin select bit
    localparam int ASP_BIT_EN        = 0;  // enable bit
    localparam int ASP_BIT_PAR_EN    = 0;  // cfg: parity enable
    localparam int ASP_BIT_PAR_ODD   = 1;  // cfg: odd parity
    localparam int ASP_BIT_TWO_STOP  = 2;  // cfg: two stop bits
    localparam int ASP_BIT_TX_DONE   = 0;  // irq: transmit complete
    localparam int ASP_BIT_RX_AVAIL  = 1;  // irq: receive ready
    localparam int ASP_BIT_PAR_ERR   = 0;  // line: parity error
    localparam int ASP_BIT_FRAME_ERR = 1;  // line: framing error
    localparam int ASP_BIT_OVERRUN   = 2;  // line: overrun
    localparam int ASP_BIT_TX_BUSY   = 3;  // line: transmitter busy
    // widths
    localparam int ASP_DATA_BITS = 8;   // fixed character length
    localparam int ASP_DIV_W     = 16;  // divisor width
    // timing: 250 khz time base from 200 mhz core clock
    localparam int ASP_CLK_HZ    = 200000000;
    localparam int ASP_BASE_HZ   = 250000;
    localparam int ASP_BASE_DIV  = ASP_CLK_HZ / ASP_BASE_HZ;
    localparam logic [9:0] ASP_BASE_LAST = 10'(ASP_BASE_DIV - 1);
    // reset values
    localparam logic [ASP_DIV_W-1:0] ASP_DIV_RST = 16'h0000;
    localparam logic [2:0] ASP_CFG_RST = 3'h0;
endpackage

/* File: rtl/asp_tx.sv */
`timescale 1ns/1ps
// frame serialiser: start, 8 data lsb first, optional parity, 1 or 2 stops
module asp_tx
    import asp_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 run,        // port enabled
    input  wire logic                 tick,       // one 250 khz pulse
    input  wire logic [ASP_DIV_W-1:0] divisor,
    input  wire logic [2:0]           cfg,
    input  wire logic                 start,      // load pulse
    input  wire logic [7:0]           data,
    output logic                      line,       // serial out
    output logic                      busy,
    output logic                      done        // one-cycle pulse
);
    typedef enum logic [2:0] {ASP_T_IDLE, ASP_T_WAIT, ASP_T_START, ASP_T_DATA,
                              ASP_T_PAR, ASP_T_STOP} asp_tx_state_t;
    asp_tx_state_t         state;    // frame phase
    logic [ASP_DIV_W-1:0]  cnt;      // ticks within bit
    logic [7:0]            shreg;    // data shifter
    logic [2:0]            bitn;     // data bit index
    logic                  par;      // running parity
    logic                  stop2;    // second stop pending
    logic                  bit_end;  // last tick of a bit
    assign bit_end = tick && (cnt == divisor);

    // bit timing and sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ASP_T_IDLE;
            cnt   <= '0;
            shreg <= '0;
            bitn  <= '0;
            par   <= 1'b0;
            stop2 <= 1'b0;
            line  <= 1'b1;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (tick) begin
                cnt <= bit_end ? '0 : cnt + 1'b1;
            end
            if (!run) begin
                state <= ASP_T_IDLE;
                line  <= 1'b1;
                busy  <= 1'b0;
            end else begin
                unique case (state)
                    ASP_T_IDLE: begin
                        if (start) begin
                            state <= ASP_T_WAIT;
                            shreg <= data;
                            par   <= cfg[ASP_BIT_PAR_ODD];
                            stop2 <= cfg[ASP_BIT_TWO_STOP];
                            bitn  <= '0;
                            busy  <= 1'b1;
                        end
                    end
                    // hold off to a tick so the start bit is full length
                    ASP_T_WAIT: begin
                        if (tick) begin
                            state <= ASP_T_START;
                            cnt   <= '0;
                            line  <= 1'b0;  // single start bit
                        end
                    end
                    ASP_T_START: begin
                        if (bit_end) begin
                            state <= ASP_T_DATA;
                            line  <= shreg[0];  // lsb first
                        end
                    end
                    ASP_T_DATA: begin
                        if (bit_end) begin
                            par   <= par ^ shreg[0];
                            shreg <= shreg >> 1;
                            bitn  <= bitn + 1'b1;
                            if (bitn == 3'(ASP_DATA_BITS - 1)) begin
                                if (cfg[ASP_BIT_PAR_EN]) begin
                                    state <= ASP_T_PAR;
                                    line  <= par ^ shreg[0];
                                end else begin
                                    state <= ASP_T_STOP;
                                    line  <= 1'b1;
                                end
                            end else begin
                                line <= shreg[1];
                            end
                        end
                    end
                    ASP_T_PAR: begin
                        if (bit_end) begin
                            state <= ASP_T_STOP;
                            line  <= 1'b1;
                        end
                    end
                    ASP_T_STOP: begin
                        if (bit_end) begin
                            if (stop2) begin
                                stop2 <= 1'b0;  // extra stop
                            end else begin
                                state <= ASP_T_IDLE;
                                busy  <= 1'b0;
                                done  <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end
endmodule

/* File: rtl/asp_rx.sv */
`timescale 1ns/1ps
// frame receiver: start edge detect, mid-bit sampling
module asp_rx
    import asp_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 run,
    input  wire logic                 tick,
    input  wire logic [ASP_DIV_W-1:0] divisor,
    input  wire logic [2:0]           cfg,
    input  wire logic                 line,       // serial in
    output logic [7:0]                data,
    output logic                      got,        // one-cycle pulse
    output logic                      par_err,    // valid with got
    output logic                      frame_err   // valid with got
);
    typedef enum logic [2:0] {ASP_R_IDLE, ASP_R_START, ASP_R_DATA,
                              ASP_R_PAR, ASP_R_STOP} asp_rx_state_t;
    asp_rx_state_t         state;   // frame phase
    logic [ASP_DIV_W-1:0]  cnt;     // ticks within bit
    logic [2:0]            bitn;    // data bit index
    logic                  par;     // running parity
    logic                  line_q;  // previous line level
    logic                  mid;     // middle of bit
    assign mid = tick && (cnt == (divisor >> 1));

    // sampling sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= ASP_R_IDLE;
            cnt       <= '0;
            bitn      <= '0;
            par       <= 1'b0;
            line_q    <= 1'b1;
            data      <= '0;
            got       <= 1'b0;
            par_err   <= 1'b0;
            frame_err <= 1'b0;
        end else begin
            got    <= 1'b0;
            line_q <= line;
            if (tick) begin
                cnt <= (cnt == divisor) ? '0 : cnt + 1'b1;
            end
            if (!run) begin
                state <= ASP_R_IDLE;
            end else begin
                unique case (state)
                    ASP_R_IDLE: begin
                        if (line_q && !line) begin  // falling edge
                            state   <= ASP_R_START;
                            cnt     <= '0;
                            bitn    <= '0;
                            par     <= cfg[ASP_BIT_PAR_ODD];
                            par_err <= 1'b0;
                        end
                    end
                    ASP_R_START: begin
                        if (mid) begin
                            state <= line ? ASP_R_IDLE : ASP_R_DATA;  // glitch reject
                        end
                    end
                    ASP_R_DATA: begin
                        if (mid) begin
                            data <= {line, data[7:1]};  // lsb first
                            par  <= par ^ line;
                            bitn <= bitn + 1'b1;
                            if (bitn == 3'(ASP_DATA_BITS - 1)) begin
                                state <= cfg[ASP_BIT_PAR_EN] ? ASP_R_PAR : ASP_R_STOP;
                            end
                        end
                    end
                    ASP_R_PAR: begin
                        if (mid) begin
                            par_err <= par ^ line;
                            state   <= ASP_R_STOP;
                        end
                    end
                    ASP_R_STOP: begin
                        if (mid) begin
                            frame_err <= !line;  // stop must be high
                            got       <= 1'b1;
                            state     <= ASP_R_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

/* File: rtl/asp_top.sv */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module asp_top
    import asp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        spi_mosi_pin,   // shared pin, serial rx when selected
    output logic             spi_miso_pin,   // shared pin, serial tx when selected
    input  wire logic        spi_miso_core,  // spi block's output data
    output logic             spi_mosi_core   // spi block's input data
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic                 pin_function_select_reg;  // serial pin select
    logic                 port_en;                  // enable bit
    logic [ASP_DIV_W-1:0] divisor;                  // bit-rate divisor
    logic [2:0]           cfg;                      // parity and stop config
    logic                 tx_done_irq_enable;       // mask bit
    logic                 rx_avail_irq_enable;      // mask bit
    logic                 tx_done_flag;             // sticky status
    logic                 rx_avail_flag;            // sticky status
    logic [7:0]           rx_buf;                   // receive buffer
    logic                 par_err;                  // sticky line errors
    logic                 frame_err;
    logic                 overrun;
    logic [9:0]           base_cnt;                 // time base divider
    logic                 tick;                     // 250 khz pulse
    logic                 wr_en;                    // write access phase
    logic                 rd_en;                    // read access phase
    logic                 tx_start;                 // buffer write pulse
    logic                 tx_busy;
    logic                 tx_done;
    logic                 tx_line;
    logic                 rx_line;
    logic [7:0]           rx_data;
    logic                 rx_got;
    logic                 rx_perr;
    logic                 rx_ferr;

    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign tx_start = wr_en && (paddr == ASP_OFF_TXBUF);
    assign rx_line  = pin_function_select_reg ? spi_mosi_pin : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // 250 khz time base, runs only while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (!port_en) begin
                base_cnt <= '0;
            end else if (base_cnt == ASP_BASE_LAST) begin
                base_cnt <= '0;
                tick     <= 1'b1;
            end else begin
                base_cnt <= base_cnt + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers, writes take effect in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_function_select_reg <= 1'b0;  // spi by default
            port_en                 <= 1'b0;
            divisor                 <= ASP_DIV_RST;
            cfg                     <= ASP_CFG_RST;
            tx_done_irq_enable      <= 1'b0;
            rx_avail_irq_enable     <= 1'b0;
        end else if (wr_en) begin
            unique case (paddr)
                ASP_OFF_PINSEL:  pin_function_select_reg <= pwdata[ASP_BIT_SEL];
                ASP_OFF_ENABLE:  port_en <= pwdata[ASP_BIT_EN];
                ASP_OFF_DIVISOR: divisor <= pwdata[ASP_DIV_W-1:0];
                ASP_OFF_CFG:     cfg <= pwdata[2:0];
                ASP_OFF_IRQ_EN: begin
                    tx_done_irq_enable  <= pwdata[ASP_BIT_TX_DONE];
                    rx_avail_irq_enable <= pwdata[ASP_BIT_RX_AVAIL];
                end
                default: ;  // other offsets hold no control state
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_done_flag  <= 1'b0;
            rx_avail_flag <= 1'b0;
        end else begin
            if (tx_done) begin
                tx_done_flag <= 1'b1;
            end else if (wr_en && paddr == ASP_OFF_IRQ_ST && pwdata[ASP_BIT_TX_DONE]) begin
                tx_done_flag <= 1'b0;
            end
            if (rx_got) begin
                rx_avail_flag <= 1'b1;
            end else if (wr_en && paddr == ASP_OFF_IRQ_ST && pwdata[ASP_BIT_RX_AVAIL]) begin
                rx_avail_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive buffer and line errors; errors clear on line status read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf    <= '0;
            par_err   <= 1'b0;
            frame_err <= 1'b0;
            overrun   <= 1'b0;
        end else begin
            if (rx_got) begin
                rx_buf    <= rx_data;
                par_err   <= rx_perr | par_err;
                frame_err <= rx_ferr | frame_err;
                overrun   <= rx_avail_flag | overrun;  // unhandled byte lost
            end else if (rd_en && paddr == ASP_OFF_LINE_ST) begin
                par_err   <= 1'b0;
                frame_err <= 1'b0;
                overrun   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait, unmapped reads zero with slverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable) begin
                unique case (paddr)
                    ASP_OFF_PINSEL:  prdata[ASP_BIT_SEL] <= pin_function_select_reg;
                    ASP_OFF_ENABLE:  prdata[ASP_BIT_EN] <= port_en;
                    ASP_OFF_DIVISOR: prdata[ASP_DIV_W-1:0] <= divisor;
                    ASP_OFF_CFG:     prdata[2:0] <= cfg;
                    ASP_OFF_IRQ_EN: begin
                        prdata[ASP_BIT_TX_DONE]  <= tx_done_irq_enable;
                        prdata[ASP_BIT_RX_AVAIL] <= rx_avail_irq_enable;
                    end
                    ASP_OFF_IRQ_ST: begin
                        prdata[ASP_BIT_TX_DONE]  <= tx_done_flag;
                        prdata[ASP_BIT_RX_AVAIL] <= rx_avail_flag;
                    end
                    ASP_OFF_TXBUF:   ;  // write only
                    ASP_OFF_RXBUF:   prdata[7:0] <= rx_buf;
                    ASP_OFF_LINE_ST: begin
                        prdata[ASP_BIT_PAR_ERR]   <= par_err;
                        prdata[ASP_BIT_FRAME_ERR] <= frame_err;
                        prdata[ASP_BIT_OVERRUN]   <= overrun;
                        prdata[ASP_BIT_TX_BUSY]   <= tx_busy;
                    end
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // combined interrupt and pin routing outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq           <= 1'b0;
            spi_miso_pin  <= 1'b1;
            spi_mosi_core <= 1'b0;
        end else begin
            irq <= (tx_done_flag && tx_done_irq_enable)
                 || (rx_avail_flag && rx_avail_irq_enable);
            spi_miso_pin  <= pin_function_select_reg ? tx_line : spi_miso_core;
            spi_mosi_core <= pin_function_select_reg ? 1'b0 : spi_mosi_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial engines
    asp_tx u_tx (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (port_en),
        .tick    (tick),
        .divisor (divisor),
        .cfg     (cfg),
        .start   (tx_start),
        .data    (pwdata[7:0]),
        .line    (tx_line),
        .busy    (tx_busy),
        .done    (tx_done)
    );

    asp_rx u_rx (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (port_en),
        .tick      (tick),
        .divisor   (divisor),
        .cfg       (cfg),
        .line      (rx_line),
        .data      (rx_data),
        .got       (rx_got),
        .par_err   (rx_perr),
        .frame_err (rx_ferr)
    );
endmodule

/* File: dv/asp_checker.sv */
`timescale 1ns/1ps
module asp_checker
    import asp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        spi_mosi_pin,
    input wire logic        spi_miso_pin,
    input wire logic        spi_miso_core,
    input wire logic        spi_mosi_core
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       sel_q;  // shadow of pin select
    logic       en_q;   // shadow of port enable
    logic [1:0] ien_q;  // shadow of irq enables
    logic       up;     // set one edge after reset
    logic       wr;     // write taking effect
    logic       setup;  // apb setup cycle
    assign wr    = psel && penable && pready && pwrite;
    assign setup = psel && !penable;
    ////////////////////////////////////////////////////////////////
    // shadow registers follow completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 1'b0;
            en_q  <= 1'b0;
            ien_q <= 2'h0;
            up    <= 1'b0;
        end else begin
            up <= 1'b1;
            if (wr && paddr == ASP_OFF_PINSEL) sel_q <= pwdata[ASP_BIT_SEL];
            if (wr && paddr == ASP_OFF_ENABLE) en_q <= pwdata[ASP_BIT_EN];
            if (wr && paddr == ASP_OFF_IRQ_EN) ien_q <= pwdata[1:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    a_miso_spi_pass: assert property (up && !sel_q && !$past(sel_q) |->
        spi_miso_pin == $past(spi_miso_core)) else $error("miso not routed to spi");
    a_mosi_spi_pass: assert property (up && !sel_q && !$past(sel_q) |->
        spi_mosi_core == $past(spi_mosi_pin)) else $error("mosi not routed to spi");
    a_mosi_blocked: assert property (sel_q && $past(sel_q) |-> !spi_mosi_core)
        else $error("spi sees serial input");
    a_off_line_idle: assert property (sel_q && $past(sel_q) && !en_q && !$past(en_q, 2)
        |-> spi_miso_pin) else $error("disabled port not idle high");
    a_irq_masked: assert property (up && ien_q == 2'h0 && $past(ien_q) == 2'h0 |-> !irq)
        else $error("irq while all masked");
    a_ready_zero_wait: assert property (setup |=> pready)
        else $error("no ready in access");
    a_ready_single: assert property (pready |=> !pready) else $error("ready held");
    a_err_unmapped: assert property (setup && paddr > ASP_OFF_LINE_ST |=> pslverr)
        else $error("no error on unmapped");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
    c_start: cover property (sel_q && en_q && !spi_miso_pin);
endmodule
bind asp_top asp_checker i_asp_checker (.*);

/* File: dv/asp_host.sv */
`timescale 1ns/1ps
// serial partner: sends frames to the port and samples its frames
module asp_host (
    input wire logic pclk,
    input wire logic rx_line,  // port transmit pin
    output logic     tx_line   // port receive pin
);
    initial tx_line = 1'b1;  // idle high
    // n bits lsb first, bc clocks each, then release high
    task automatic send(input logic [11:0] f, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            tx_line <= f[i];
            repeat (bc) @(posedge pclk);
        end
        tx_line <= 1'b1;
    endtask
    // wait for start edge, then sample each bit mid-period
    task automatic recv(output logic [11:0] f, input int n, input int bc);
        int k;
        f = 12'hfff;
        k = 0;
        while (rx_line !== 1'b0 && k < 4 * bc) begin
            @(posedge pclk);
            k++;
        end
        repeat (bc / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            f[i] = rx_line;
            repeat (bc) @(posedge pclk);
        end
    endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ps
module tb;
    import asp_pkg::*;
    localparam int BC = ASP_BASE_DIV;  // clocks per bit at divisor 0
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mosi_pin, miso_pin, miso_core, mosi_core, lerr;
    logic [11:0] fr;
    int          n_fail, checked;
    logic [2:0]  cf [3] = '{3'h1, 3'h3, 3'h4};  // even, odd, none with two stops
    asp_top i_asp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .spi_mosi_pin(mosi_pin), .spi_miso_pin(miso_pin),
        .spi_miso_core(miso_core), .spi_mosi_core(mosi_core));
    asp_host i_asp_host (.pclk(pclk), .rx_line(miso_pin), .tx_line(mosi_pin));
    always #2.5 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_fail++;
        rd = prdata;
        lerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // expected frame: start, data lsb first, parity, stops
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [2:0] c);
        frame = 12'hfff;
        frame[8:0] = {d, 1'b0};
        if (c[ASP_BIT_PAR_EN]) frame[9] = ^d ^ c[ASP_BIT_PAR_ODD];
    endfunction
    task automatic report_and_stop();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #500000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, miso_core} = '0;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("cfg", ASP_OFF_CFG, 32'h0);
        rdc("unmapped", 8'h24, 32'h0);
        chk("slverr", {31'h0, lerr}, 32'h1);
        chk("miso spi", {31'h0, miso_pin}, 32'h0);
        chk("mosi spi", {31'h0, mosi_core}, 32'h1);
        miso_core <= 1'b1;
        apb(1'b1, ASP_OFF_PINSEL, 32'h1);
        chk("miso spi hi", {31'h0, miso_pin}, 32'h1);
        apb(1'b1, ASP_OFF_TXBUF, 32'h55);
        rdc("busy off", ASP_OFF_LINE_ST, 32'h0);
        chk("miso serial", {31'h0, miso_pin}, 32'h1);
        chk("mosi serial", {31'h0, mosi_core}, 32'h0);
        $display("test route done");
        apb(1'b1, ASP_OFF_DIVISOR, 32'h0);
        apb(1'b1, ASP_OFF_ENABLE, 32'h1);
        apb(1'b1, ASP_OFF_IRQ_EN, 32'h1);
        foreach (cf[i]) begin
            apb(1'b1, ASP_OFF_CFG, {29'h0, cf[i]});
            apb(1'b1, ASP_OFF_TXBUF, {24'h0, 8'ha5 ^ 8'(i)});
            i_asp_host.recv(fr, 10 + cf[i][0] + cf[i][2], BC);
            chk("tx frame", {20'h0, fr}, {20'h0, frame(8'ha5 ^ 8'(i), cf[i])});
            for (int k = 0; k < 4 * BC && irq !== 1'b1; k++) @(posedge pclk);
            chk("tx irq", {31'h0, irq}, 32'h1);
            rdc("tx flag", ASP_OFF_IRQ_ST, 32'h1);
            rdc("tx flag held", ASP_OFF_IRQ_ST, 32'h1);
            apb(1'b1, ASP_OFF_IRQ_ST, 32'h1);
            rdc("tx flag clr", ASP_OFF_IRQ_ST, 32'h0);
            chk("irq low", {31'h0, irq}, 32'h0);
        end
        $display("test transmit done");
        apb(1'b1, ASP_OFF_CFG, 32'h1);
        for (int j = 0; j < 3; j++) begin
            fr = frame(8'h96 + 8'(j), 3'h1);
            if (j == 1) fr[9] = ~fr[9];
            if (j == 2) fr[10] = 1'b0;
            i_asp_host.send(fr, 11, BC);
            chk("rx masked", {31'h0, irq}, 32'h0);
            rdc("rx buf", ASP_OFF_RXBUF, {24'h0, 8'h96 + 8'(j)});
            rdc("rx flag", ASP_OFF_IRQ_ST, 32'h2);
            rdc("line st", ASP_OFF_LINE_ST, (j == 0) ? 32'h0 : 32'(j));
            if (j == 2) begin
                apb(1'b1, ASP_OFF_IRQ_EN, 32'h3);
                rdc("rx flag held", ASP_OFF_IRQ_ST, 32'h2);
                chk("rx irq", {31'h0, irq}, 32'h1);
            end
            apb(1'b1, ASP_OFF_IRQ_ST, 32'h2);
            rdc("rx flag clr", ASP_OFF_IRQ_ST, 32'h0);
        end
        $display("test receive done");
        report_and_stop();
    end
endmodule
